// File: rtl/rxe_error_flags.sv
// Receive overrun and parity error flags with error interrupt request
`timescale 1ns/100ps
`default_nettype none

module rxe_error_flags
   import rxe_pkg::*;
#(
   parameter int unsigned CHAR_W = CHAR_MAX_W
)
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_module_reset,
   input wire logic i_software_reset_n,
   input wire logic i_lin_mode,
   input wire logic [GC1_W-1:0] i_global_control_1,
   input wire logic i_parity_odd,
   input wire logic i_addr_bit_mode,
   input wire logic i_rx_xfer,
   input wire logic i_rx_unread,
   input wire logic i_rx_char_done,
   input wire logic [CHAR_W-1:0] i_rx_data,
   input wire logic [CHAR_LEN_W-1:0] i_rx_char_len,
   input wire logic i_rx_addr_bit,
   input wire logic i_rx_parity_bit,
   input wire logic i_overrun_irq_enable,
   input wire logic i_parity_irq_enable,
   input wire logic i_flags_wr,
   input wire logic [FLAGS_W-1:0] i_flags_wdata,
   input wire logic i_vect_rd,
   input wire logic [VECT_W-1:0] i_interrupt_vector_offset,
   output logic o_overrun_error_flag,
   output logic o_parity_error_flag,
   output logic [FLAGS_W-1:0] o_flags_word,
   output logic o_error_irq,
   output logic [VECT_W-1:0] o_pending_offset,
   output logic o_last_expected_parity
);

   generate
      if (CHAR_W < 1 || CHAR_W > CHAR_MAX_W)
      begin : g_bad_char_w
         $error("rxe_error_flags: CHAR_W must be 1 to 8");
      end
      // Flag positions must land inside the words that carry them
      if (FLAG_OVERRUN_BIT >= FLAGS_W || FLAG_PARITY_BIT >= FLAGS_W)
      begin : g_bad_flag_pos
         $error("rxe_error_flags: flag position outside the flags word");
      end
      if (FLAG_OVERRUN_BIT == FLAG_PARITY_BIT)
      begin : g_same_flag_pos
         $error("rxe_error_flags: flags share one position");
      end
      if (GC1_PARITY_EN_BIT >= GC1_W)
      begin : g_bad_enable_pos
         $error("rxe_error_flags: parity enable outside global_control_1");
      end
   endgenerate

   // Character framing and parity check
   logic [CHAR_LEN_W-1:0] eff_len;
   logic [CHAR_W-1:0] len_mask;
   logic use_addr_bit;
   logic expected_parity;
   logic parity_enabled;
   logic parity_mismatch;

   // LIN frames fixed at eight bits
   always_comb
   begin
      if (i_lin_mode)
      begin
         eff_len = LIN_CHAR_LEN;
      end
      else
      begin
         eff_len = i_rx_char_len;
      end
   end

   always_comb
   begin
      len_mask = '0;
      for (int unsigned k = 0; k < CHAR_W; k++)
      begin
         len_mask[k] = (k <= 32'(eff_len));
      end
   end

   // Idle-line uses data only
   // LIN has no address-bit framing, so the mode bit is ignored there
   assign use_addr_bit = i_addr_bit_mode && !i_lin_mode;

   rxe_parity_calc
   #(
      .WIDTH(CHAR_W)
   )
   u_parity
   (
      .i_bits(i_rx_data),
      .i_mask(len_mask),
      .i_include_extra(use_addr_bit),
      .i_extra(i_rx_addr_bit),
      .i_odd(i_parity_odd),
      .o_expected(expected_parity)
   );

   assign parity_enabled = i_global_control_1[GC1_PARITY_EN_BIT];

   assign parity_mismatch = (expected_parity != i_rx_parity_bit);

   // Set and clear terms
   logic set_overrun;
   logic set_parity;
   logic hard_clear;
   logic wr_clr_overrun;
   logic wr_clr_parity;
   logic vect_clr_overrun;
   logic vect_clr_parity;
   logic clr_overrun;
   logic clr_parity;

   assign set_overrun = i_rx_xfer && i_rx_unread;

   assign set_parity = i_rx_char_done && parity_enabled && parity_mismatch;

   // Same sources for parity
   // Resets dominate any event: a held reset must keep flags low
   assign hard_clear = i_module_reset || !i_software_reset_n;

   // Only a one clears on write
   assign wr_clr_overrun = i_flags_wr && i_flags_wdata[FLAG_OVERRUN_BIT];
   assign wr_clr_parity = i_flags_wr && i_flags_wdata[FLAG_PARITY_BIT];

   assign vect_clr_overrun = i_vect_rd && (i_interrupt_vector_offset == VECT_OVERRUN);
   assign vect_clr_parity = i_vect_rd && (i_interrupt_vector_offset == VECT_PARITY);

   // Each flag has its own clear term
   assign clr_overrun = wr_clr_overrun || vect_clr_overrun;
   assign clr_parity = wr_clr_parity || vect_clr_parity;

   // Flag state
   logic overrun_q;
   logic overrun_d;
   logic parity_q;
   logic parity_d;
   logic parity_visible;
   logic overrun_pending;
   logic parity_pending;

   always_comb
   begin
      overrun_d = overrun_q;
      if (hard_clear)
      begin
         overrun_d = FLAG_RESET_VAL;
      end
      // Set beats a software clear in the same cycle, so no event is lost
      else if (set_overrun)
      begin
         overrun_d = 1'b1;
      end
      else if (clr_overrun)
      begin
         overrun_d = 1'b0;
      end
   end

   always_comb
   begin
      parity_d = parity_q;
      if (hard_clear || !parity_enabled)
      begin
         parity_d = FLAG_RESET_VAL;
      end
      else if (set_parity)
      begin
         parity_d = 1'b1;
      end
      else if (clr_parity)
      begin
         parity_d = 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         overrun_q <= FLAG_RESET_VAL;
      end
      else
      begin
         overrun_q <= overrun_d;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         parity_q <= FLAG_RESET_VAL;
      end
      else
      begin
         parity_q <= parity_d;
      end
   end

   // Last computed parity, kept for diagnostics
   logic last_par_q;
   logic last_par_d;

   always_comb
   begin
      last_par_d = last_par_q;
      if (hard_clear)
      begin
         last_par_d = FLAG_RESET_VAL;
      end
      else if (i_rx_char_done)
      begin
         last_par_d = expected_parity;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         last_par_q <= FLAG_RESET_VAL;
      end
      else
      begin
         last_par_q <= last_par_d;
      end
   end

   // Outputs
   // Disabled parity reads as zero
   // Masked here as well, so a disable acts before the stored flag clears
   assign parity_visible = parity_q && parity_enabled;

   assign o_overrun_error_flag = overrun_q;
   assign o_parity_error_flag = parity_visible;
   assign o_last_expected_parity = last_par_q;

   // Other bits of the flags word belong to other logic and read zero here
   always_comb
   begin
      o_flags_word = '0;
      o_flags_word[FLAG_OVERRUN_BIT] = overrun_q;
      o_flags_word[FLAG_PARITY_BIT] = parity_visible;
   end

   assign overrun_pending = overrun_q && i_overrun_irq_enable;

   assign parity_pending = parity_visible && i_parity_irq_enable;

   assign o_error_irq = overrun_pending || parity_pending;

   // Offset the vector register would return; parity ranks first
   always_comb
   begin
      if (parity_pending)
      begin
         o_pending_offset = VECT_PARITY;
      end
      else if (overrun_pending)
      begin
         o_pending_offset = VECT_OVERRUN;
      end
      else
      begin
         o_pending_offset = VECT_NONE;
      end
   end

endmodule

`default_nettype wire

// File: rtl/rxe_parity_calc.sv
// Parity generator over a masked character and an optional extra bit
`timescale 1ns/100ps
`default_nettype none

module rxe_parity_calc
#(
   parameter int unsigned WIDTH = 8
)
(
   input wire logic [WIDTH-1:0] i_bits,
   input wire logic [WIDTH-1:0] i_mask,
   input wire logic i_include_extra,
   input wire logic i_extra,
   input wire logic i_odd,
   output logic o_expected
);

   generate
      if (WIDTH < 1 || WIDTH > 32)
      begin : g_bad_width
         $error("rxe_parity_calc: WIDTH out of range");
      end
   endgenerate

   logic ones_xor;

   always_comb
   begin
      ones_xor = ^(i_bits & i_mask);
      if (i_include_extra)
      begin
         ones_xor = ones_xor ^ i_extra;
      end
      // Even parity: bit makes total ones even; odd inverts it
      o_expected = ones_xor ^ i_odd;
   end

endmodule

`default_nettype wire

// File: rtl/rxe_pkg.sv
// Constants for the receive overrun and parity error flag logic
`default_nettype none
package rxe_pkg;

   // Flag positions inside the 32-bit flags word
   localparam int unsigned FLAG_OVERRUN_BIT = 25;
   localparam int unsigned FLAG_PARITY_BIT = 24;
   localparam int unsigned FLAGS_W = 32;

   // Parity enable position inside global_control_1
   localparam int unsigned GC1_PARITY_EN_BIT = 2;
   localparam int unsigned GC1_W = 32;

   // Interrupt vector offsets returned for each flag
   localparam int unsigned VECT_W = 5;
   localparam logic [4:0] VECT_NONE = 5'h00;
   localparam logic [4:0] VECT_PARITY = 5'h09;
   localparam logic [4:0] VECT_OVERRUN = 5'h0b;

   // Character framing
   localparam int unsigned CHAR_MAX_W = 8;
   localparam int unsigned CHAR_LEN_W = 3;
   localparam logic [2:0] LIN_CHAR_LEN = 3'h7;

   // Values after reset
   localparam logic FLAG_RESET_VAL = 1'b0;
   localparam logic [7:0] CHAR_RESET_VAL = 8'h00;
   localparam logic [2:0] LEN_RESET_VAL = 3'h0;

endpackage
`default_nettype wire

// File: verif/rxe_error_flags_sva.sv
// Checker for the receive error flags
`timescale 1ns/100ps
`default_nettype none
module rxe_error_flags_sva
(
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_module_reset,
   input wire logic i_software_reset_n,
   input wire logic [31:0] i_global_control_1,
   input wire logic i_rx_xfer,
   input wire logic i_rx_unread,
   input wire logic i_rx_char_done,
   input wire logic i_overrun_irq_enable,
   input wire logic i_parity_irq_enable,
   input wire logic i_flags_wr,
   input wire logic [31:0] i_flags_wdata,
   input wire logic i_vect_rd,
   input wire logic [4:0] i_interrupt_vector_offset,
   input wire logic o_overrun_error_flag,
   input wire logic o_parity_error_flag,
   input wire logic [31:0] o_flags_word,
   input wire logic o_error_irq
);
   wire logic ov = o_overrun_error_flag;
   wire logic pe = o_parity_error_flag;
   wire logic run = !i_module_reset && i_software_reset_n;
   wire logic vr9 = i_vect_rd && i_interrupt_vector_offset == 5'h09;
   wire logic vrb = i_vect_rd && i_interrupt_vector_offset == 5'h0b;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   ovr_set_a: assert property (run && i_rx_xfer && i_rx_unread |=> ov)
      else $error("overrun not set");
   error_irq_a: assert property (o_error_irq == (ov && i_overrun_irq_enable || pe && i_parity_irq_enable))
      else $error("error request wrong");
   ovr_wr1_a: assert property (i_flags_wr && i_flags_wdata[25] && !i_rx_xfer |=> !ov)
      else $error("overrun not cleared");
   ovr_keep_a: assert property (ov && run && !(i_flags_wr && i_flags_wdata[25]) && !vrb |=> ov)
      else $error("overrun lost");
   soft_rst_a: assert property (!run |=> !ov && !pe)
      else $error("reset left a flag");
   par_off_a: assert property (!i_global_control_1[2] |-> !pe ##1 !pe)
      else $error("parity flag while disabled");
   par_wr1_a: assert property (i_flags_wr && i_flags_wdata[24] && !i_rx_char_done |=> !pe)
      else $error("parity not cleared");
   par_vect_a: assert property (vr9 && !i_rx_char_done |=> !pe)
      else $error("vector read kept parity");
   flag_word_a: assert property (o_flags_word == {6'h00, ov, pe, 24'h000000})
      else $error("flags word layout");
   cover property (i_rx_xfer && i_rx_unread);
   cover property (vr9 && ov && pe);
   cover property (!run && ov);
endmodule
bind rxe_error_flags rxe_error_flags_sva u_sva (.i_mclk, .i_nrst, .i_module_reset,
   .i_software_reset_n, .i_global_control_1, .i_rx_xfer, .i_rx_unread, .i_rx_char_done,
   .i_overrun_irq_enable, .i_parity_irq_enable, .i_flags_wr, .i_flags_wdata, .i_vect_rd,
   .i_interrupt_vector_offset, .o_overrun_error_flag, .o_parity_error_flag, .o_flags_word,
   .o_error_irq);
`default_nettype wire

// File: verif/rxe_tx_node.sv
// Behavioural far node that delivers received characters
`timescale 1ns/100ps
`default_nettype none
module rxe_tx_node
(
   input wire logic i_mclk,
   input wire logic i_lin,
   input wire logic i_addr_mode,
   input wire logic i_odd,
   input wire logic [2:0] i_len,
   output logic o_done = 1'b0,
   output logic [7:0] o_data = 8'h00,
   output logic o_addr = 1'b0,
   output logic o_par = 1'b0,
   output logic o_xfer = 1'b0,
   output logic o_unread = 1'b0,
   output logic o_exp = 1'b0
);
   task automatic send(input logic [7:0] d, input logic a, input logic bad);
      logic [7:0] m;
      @(posedge i_mclk);
      // Mode read after the edge so the bench's last update has landed
      m = i_lin ? 8'hff : 8'hff >> (3'h7 - i_len);
      o_exp = ^(d & m) ^ (a & i_addr_mode & !i_lin) ^ i_odd;
      o_done <= 1'b1;
      o_data <= d;
      o_addr <= a;
      o_par <= o_exp ^ bad;
      @(posedge i_mclk);
      // Lines no longer valid show inverted data
      o_done <= 1'b0;
      o_data <= ~d;
      o_addr <= ~a;
      o_par <= ~o_par;
   endtask
   task automatic xfer(input logic u);
      @(posedge i_mclk);
      o_xfer <= 1'b1;
      o_unread <= u;
      @(posedge i_mclk);
      o_xfer <= 1'b0;
      o_unread <= ~u;
   endtask
endmodule
`default_nettype wire

// File: verif/tb_rxe_error_flags.sv
// Testbench for the receive error flags
`timescale 1ns/100ps
`default_nettype none
module tb_rxe_error_flags;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic mr = 1'b0, lin = 1'b0, am = 1'b0, odd = 1'b0, wr = 1'b0, vr = 1'b0;
   logic srn = 1'b1, oie = 1'b1, pie = 1'b1;
   logic [2:0] len = 3'h7;
   logic [31:0] gc = 32'h00000004, wd = 32'h0;
   logic [4:0] vo = 5'h00;
   wire logic dn, ad, pb, xf, ur, ex, ov, pe, irq, lp;
   wire logic [7:0] dt;
   wire logic [31:0] fw;
   wire logic [4:0] po;
   int fails = 0, checks = 0;
   initial forever #25 i_mclk = ~i_mclk;
   rxe_error_flags DUT (.i_mclk, .i_nrst, .i_module_reset(mr), .i_software_reset_n(srn),
      .i_lin_mode(lin), .i_global_control_1(gc), .i_parity_odd(odd), .i_addr_bit_mode(am),
      .i_rx_xfer(xf), .i_rx_unread(ur), .i_rx_char_done(dn), .i_rx_data(dt),
      .i_rx_char_len(len), .i_rx_addr_bit(ad), .i_rx_parity_bit(pb),
      .i_overrun_irq_enable(oie), .i_parity_irq_enable(pie), .i_flags_wr(wr),
      .i_flags_wdata(wd), .i_vect_rd(vr), .i_interrupt_vector_offset(vo),
      .o_overrun_error_flag(ov), .o_parity_error_flag(pe), .o_flags_word(fw),
      .o_error_irq(irq), .o_pending_offset(po), .o_last_expected_parity(lp));
   rxe_tx_node u_tx (.i_mclk, .i_lin(lin), .i_addr_mode(am), .i_odd(odd), .i_len(len),
      .o_done(dn), .o_data(dt), .o_addr(ad), .o_par(pb), .o_xfer(xf), .o_unread(ur), .o_exp(ex));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Sampled mid-cycle, after the taking edge has settled
   task automatic st(input logic o, input logic p, input logic [4:0] f);
      @(negedge i_mclk);
      chk({ov, pe}, {o, p});
      chk(fw, {6'h00, o, p, 24'h000000});
      chk({irq, po}, {(o & oie) | (p & pie), f});
   endtask
   task automatic wf(input logic [31:0] d);
      @(posedge i_mclk);
      wr <= 1'b1;
      wd <= d;
      @(posedge i_mclk);
      wr <= 1'b0;
      wd <= ~d;
   endtask
   task automatic vrd(input logic [4:0] f);
      @(posedge i_mclk);
      vr <= 1'b1;
      vo <= f;
      @(posedge i_mclk);
      vr <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge i_mclk);
      fails++;
      give_verdict();
   end
   initial
   begin
      repeat (20) @(posedge i_mclk);
      i_nrst <= 1'b1;
      st(0, 0, 5'h00);
      u_tx.xfer(1'b0);
      st(0, 0, 5'h00);
      u_tx.xfer(1'b1);
      st(1, 0, 5'h0b);
      @(posedge i_mclk);
      oie <= 1'b0;
      st(1, 0, 5'h00);
      @(posedge i_mclk);
      oie <= 1'b1;
      wf(32'hfcffffff);
      st(1, 0, 5'h0b);
      wf(32'h01000000);
      st(1, 0, 5'h0b);
      wf(32'h02000000);
      st(0, 0, 5'h00);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge i_mclk);
         lin <= i[1];
         am <= i[0];
         odd <= i[0] ^ i[1];
         len <= 3'h4 + i[1:0];
         u_tx.send(8'he5, 1'b1, 1'b0);
         st(0, 0, 5'h00);
         chk(lp, ex);
         u_tx.send(8'h5b, 1'b0, 1'b1);
         st(0, 1, 5'h09);
         @(posedge i_mclk);
         pie <= 1'b0;
         st(0, 1, 5'h00);
         @(posedge i_mclk);
         pie <= 1'b1;
         wf(32'hfeffffff);
         st(0, 1, 5'h09);
         wf(32'h01000000);
         st(0, 0, 5'h00);
      end
      u_tx.xfer(1'b1);
      u_tx.send(8'h01, 1'b0, 1'b1);
      st(1, 1, 5'h09);
      vrd(5'h01);
      st(1, 1, 5'h09);
      vrd(5'h09);
      st(1, 0, 5'h0b);
      vrd(5'h0b);
      st(0, 0, 5'h00);
      u_tx.send(8'h01, 1'b0, 1'b1);
      @(posedge i_mclk);
      gc <= 32'hfffffffb;
      st(0, 0, 5'h00);
      u_tx.send(8'h01, 1'b0, 1'b1);
      st(0, 0, 5'h00);
      @(posedge i_mclk);
      gc <= 32'h00000004;
      st(0, 0, 5'h00);
      for (int k = 0; k < 3; k++)
      begin
         u_tx.xfer(1'b1);
         u_tx.send(8'h01, 1'b0, 1'b1);
         st(1, 1, 5'h09);
         @(posedge i_mclk);
         mr <= (k == 0);
         srn <= (k != 1);
         i_nrst <= (k != 2);
         @(posedge i_mclk);
         mr <= 1'b0;
         srn <= 1'b1;
         i_nrst <= 1'b1;
         st(0, 0, 5'h00);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
